// ---- rcr_pkg.sv ----
// constants for the radio control and revision register block
// assumes a 50 MHz mclk and a byte-wide decoded register port
package rcr_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_REV_ID = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RADIO_CTRL = 6'h03;
  localparam logic [DATA_W-1:0] RADIO_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RESERVED_MASK = 8'hFC;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  localparam int BIT_RX_EN = 7;
  localparam int BIT_TX_EN = 6;
  localparam int BIT_CODE_HALF = 5;
  localparam int BIT_LOCK_BYPASS = 4;
  localparam int BIT_AMP_SRC = 3;
  localparam int BIT_AMP_EN = 2;
  localparam int SILICON_REV_MSB = 7;
  localparam int SILICON_REV_LSB = 4;
  localparam int PRODUCT_CODE_MSB = 3;
  localparam int PRODUCT_CODE_LSB = 0;
  localparam int MCLK_PERIOD_NS = 20;
  localparam int SETTLE_UNIT_NS = 2000;
  localparam int SETTLE_UNIT_CYCLES = (SETTLE_UNIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int PREDIV_W = 7;
  localparam int CYC_W = 16;
  typedef enum logic [1:0] {
    SETTLE_IDLE,
    SETTLE_WAIT_LOCK,
    SETTLE_COUNT,
    SETTLE_DONE
  } rcr_settle_e;
endpackage

// ---- rcr_settle.sv ----
// synthesizer settle sequencer: optional wait for lock, then a timed delay
// assumes lock_sync is already synchronised to mclk; lock count stable while running
`timescale 1ns/1ps
`default_nettype none
module rcr_settle (
  input wire logic mclk,
  input wire logic rst,
  input wire logic settle_start,
  input wire logic lock_bypass,
  input wire logic lock_sync,
  input wire logic [7:0] lock_count,
  output logic settle_busy,
  output logic settle_done
);
  rcr_pkg::rcr_settle_e state_ff;
  logic [rcr_pkg::PREDIV_W-1:0] prediv_ff;
  logic [7:0] units_ff;
  logic unit_tick;
  logic [rcr_pkg::CYC_W-1:0] cyc_ff;

  // one enable pulse every 2 us while counting
  assign unit_tick = (state_ff == rcr_pkg::SETTLE_COUNT) &&
                     (prediv_ff == rcr_pkg::PREDIV_W'(rcr_pkg::SETTLE_UNIT_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= rcr_pkg::SETTLE_IDLE;
    end else if (settle_start) begin
      // bypass skips the lock wait entirely
      state_ff <= lock_bypass ? rcr_pkg::SETTLE_COUNT : rcr_pkg::SETTLE_WAIT_LOCK;
    end else begin
      case (state_ff)
        rcr_pkg::SETTLE_IDLE: state_ff <= rcr_pkg::SETTLE_IDLE;
        rcr_pkg::SETTLE_WAIT_LOCK: begin
          if (lock_sync) begin
            state_ff <= rcr_pkg::SETTLE_COUNT;
          end
        end
        rcr_pkg::SETTLE_COUNT: begin
          if (units_ff == lock_count) begin
            state_ff <= rcr_pkg::SETTLE_DONE;
          end
        end
        rcr_pkg::SETTLE_DONE: state_ff <= rcr_pkg::SETTLE_DONE;
        default: state_ff <= rcr_pkg::SETTLE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || settle_start || state_ff != rcr_pkg::SETTLE_COUNT) begin
      prediv_ff <= '0;
      units_ff <= 8'h00;
    end else if (unit_tick) begin
      prediv_ff <= '0;
      units_ff <= units_ff + 8'h01;
    end else begin
      prediv_ff <= prediv_ff + 7'h01;
    end
  end

  assign settle_busy = (state_ff == rcr_pkg::SETTLE_WAIT_LOCK) ||
                       (state_ff == rcr_pkg::SETTLE_COUNT);
  assign settle_done = (state_ff == rcr_pkg::SETTLE_DONE);

  // helper: cycles spent in the timed phase; a restart while timing begins a fresh count
  always_ff @(posedge mclk) begin
    if (rst || settle_start || state_ff != rcr_pkg::SETTLE_COUNT) begin
      cyc_ff <= '0;
    end else begin
      cyc_ff <= cyc_ff + 16'h0001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_start_bypass;
    settle_start && lock_bypass;
  endsequence
  sequence s_start_locked;
    settle_start && !lock_bypass;
  endsequence

  a_bypass_skips_lock: assert property (s_start_bypass |=> state_ff == rcr_pkg::SETTLE_COUNT)
    else $error("bypass start did not go straight to timing");
  a_waits_for_lock: assert property (s_start_locked ##1 (!lock_sync && !settle_start)
      |=> !settle_done && state_ff != rcr_pkg::SETTLE_COUNT)
    else $error("timing began before lock");
  a_lock_then_count: assert property ((state_ff == rcr_pkg::SETTLE_WAIT_LOCK) && lock_sync
      && !settle_start |=> state_ff == rcr_pkg::SETTLE_COUNT)
    else $error("lock did not start timing");
  a_settle_unit_time: assert property ((state_ff == rcr_pkg::SETTLE_COUNT) && !settle_start
      && (units_ff == lock_count)
      |-> cyc_ff == 16'(lock_count) * 16'(rcr_pkg::SETTLE_UNIT_CYCLES))
    else $error("settle delay not lock count times 2 us");
endmodule
`default_nettype wire

// ---- rcr_radio_regs.sv ----
// revision identification and radio control registers with settle sequencing
// assumes the serial port engine hands over decoded one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
module rcr_radio_regs #(
  parameter logic [3:0] SILICON_REV = 4'h2, // arbitrary value
  parameter logic [3:0] PRODUCT_CODE = 4'hA // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [rcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic code_width_32,
  input wire logic [7:0] lock_count,
  input wire logic syn_lock,
  input wire logic baseband_amp_req,
  input wire logic settle_start,
  output logic rx_mode,
  output logic tx_mode,
  output logic chips_32_mode,
  output logic code_upper_half,
  output logic amp_on,
  output logic settle_busy,
  output logic settle_done
);
  logic [rcr_pkg::DATA_W-1:0] ctrl_ff;
  logic [rcr_pkg::DATA_W-1:0] rdata_ff;
  logic [rcr_pkg::DATA_W-1:0] id_value;
  logic lock_meta_ff;
  logic lock_sync_ff;
  logic rx_ff;
  logic tx_ff;
  logic chips32_ff;
  logic upper_ff;
  logic amp_ff;

  function automatic logic hit(input logic [rcr_pkg::ADDR_W-1:0] a,
                               input logic [rcr_pkg::ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  always_comb begin
    id_value = '0;
    id_value[rcr_pkg::SILICON_REV_MSB:rcr_pkg::SILICON_REV_LSB] = SILICON_REV;
    id_value[rcr_pkg::PRODUCT_CODE_MSB:rcr_pkg::PRODUCT_CODE_LSB] = PRODUCT_CODE;
  end

  // identification has no write path at all
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= rcr_pkg::RADIO_CTRL_RESET;
    end else if (reg_wr && hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL)) begin
      // reserved bits kept at zero even if firmware writes ones
      ctrl_ff <= reg_wdata & rcr_pkg::RESERVED_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= rcr_pkg::UNMAPPED_READ;
    end else if (reg_rd) begin
      if (hit(reg_addr, rcr_pkg::ADDR_REV_ID)) begin
        rdata_ff <= id_value;
      end else if (hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL)) begin
        rdata_ff <= ctrl_ff;
      end else begin
        rdata_ff <= rcr_pkg::UNMAPPED_READ;
      end
    end
  end
  assign reg_rdata = rdata_ff;

  // lock comes from the analog synthesizer, so it is synchronised
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_meta_ff <= 1'b0;
      lock_sync_ff <= 1'b0;
    end else begin
      lock_meta_ff <= syn_lock;
      lock_sync_ff <= lock_meta_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_ff <= 1'b0;
      tx_ff <= 1'b0;
    end else begin
      rx_ff <= ctrl_ff[rcr_pkg::BIT_RX_EN];
      tx_ff <= ctrl_ff[rcr_pkg::BIT_TX_EN];
    end
  end

  // in 64-chip mode the whole code is used, so the half select is forced low
  always_ff @(posedge mclk) begin
    if (rst) begin
      chips32_ff <= 1'b0;
      upper_ff <= 1'b0;
    end else begin
      chips32_ff <= code_width_32;
      upper_ff <= code_width_32 && ctrl_ff[rcr_pkg::BIT_CODE_HALF];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      amp_ff <= 1'b0;
    end else if (ctrl_ff[rcr_pkg::BIT_AMP_SRC]) begin
      amp_ff <= ctrl_ff[rcr_pkg::BIT_AMP_EN];
    end else begin
      amp_ff <= baseband_amp_req;
    end
  end

  assign rx_mode = rx_ff;
  assign tx_mode = tx_ff;
  assign chips_32_mode = chips32_ff;
  assign code_upper_half = upper_ff;
  assign amp_on = amp_ff;

  rcr_settle u_settle (
    .mclk(mclk),
    .rst(rst),
    .settle_start(settle_start),
    .lock_bypass(ctrl_ff[rcr_pkg::BIT_LOCK_BYPASS]),
    .lock_sync(lock_sync_ff),
    .lock_count(lock_count),
    .settle_busy(settle_busy),
    .settle_done(settle_done)
  );

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_id_read_fixed: assert property (reg_rd && hit(reg_addr, rcr_pkg::ADDR_REV_ID)
      |=> reg_rdata[7:4] == SILICON_REV && reg_rdata[3:0] == PRODUCT_CODE)
    else $error("identification read returned wrong fields");
  // the host may leave an idle cycle between the write and the read back
  a_id_write_ignored: assert property (reg_wr && hit(reg_addr, rcr_pkg::ADDR_REV_ID)
      ##[1:2] reg_rd && hit(reg_addr, rcr_pkg::ADDR_REV_ID) |=> reg_rdata == id_value)
    else $error("identification changed by a write");
  a_rx_follows_bit: assert property (reg_wr && hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL)
      |=> ##1 rx_mode == $past(reg_wdata[7], 2))
    else $error("receive mode does not follow control bit");
  a_tx_follows_bit: assert property (reg_wr && hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL)
      |=> ##1 tx_mode == $past(reg_wdata[6], 2))
    else $error("transmit mode does not follow control bit");
  a_half_gated: assert property (!code_width_32 |=> !code_upper_half)
    else $error("code half select active in 64-chip mode");
  a_half_select: assert property (code_width_32 && ctrl_ff[rcr_pkg::BIT_CODE_HALF]
      |=> code_upper_half && chips_32_mode)
    else $error("upper half not selected");
  a_amp_manual: assert property (ctrl_ff[rcr_pkg::BIT_AMP_SRC]
      |=> amp_on == $past(ctrl_ff[rcr_pkg::BIT_AMP_EN]))
    else $error("amplifier ignores enable bit under register control");
  a_amp_auto: assert property (!ctrl_ff[rcr_pkg::BIT_AMP_SRC]
      |=> amp_on == $past(baseband_amp_req))
    else $error("amplifier ignores baseband under auto control");
  a_ctrl_reset_zero: assert property ($past(rst) |-> ctrl_ff == rcr_pkg::RADIO_CTRL_RESET)
    else $error("control register not zero after reset");

  // register port steps, named once and reused by the checks below
  sequence s_ctrl_write;
    reg_wr && hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL);
  endsequence
  sequence s_ctrl_read;
    reg_rd && hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL);
  endsequence
  sequence s_other_read;
    reg_rd && !hit(reg_addr, rcr_pkg::ADDR_REV_ID)
      && !hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL);
  endsequence
  sequence s_ctrl_idle;
    !(reg_wr && hit(reg_addr, rcr_pkg::ADDR_RADIO_CTRL));
  endsequence

  // stored value is the masked write data, nothing else moves it
  a_ctrl_write_lands: assert property (s_ctrl_write
      |=> ctrl_ff == ($past(reg_wdata) & rcr_pkg::RESERVED_MASK))
    else $error("control write did not land");
  a_ctrl_holds: assert property (s_ctrl_idle
      |=> $stable(ctrl_ff))
    else $error("control changed without a write");

  // firmware may poll read data, so it must not drift between reads
  a_ctrl_read_back: assert property (s_ctrl_read
      |=> reg_rdata == $past(ctrl_ff))
    else $error("control read returned wrong value");
  a_unmapped_zero: assert property (s_other_read
      |=> reg_rdata == rcr_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // reserved bits stored as zero so a stray write never reaches them later
  a_reserved_zero: assert property ((ctrl_ff & ~rcr_pkg::RESERVED_MASK) == '0)
    else $error("reserved control bits not zero");
  a_chips_follow: assert property (1'b1 |=> chips_32_mode == $past(code_width_32))
    else $error("chip width output does not follow input");

  a_modes_reset_off: assert property ($past(rst)
      |-> !rx_mode && !tx_mode && !code_upper_half)
    else $error("mode outputs not off after reset");
  a_amp_reset_off: assert property ($past(rst) |-> !amp_on)
    else $error("amplifier not off after reset");
endmodule
`default_nettype wire

// ---- rcr_host_model.sv ----
// host register master model driving decoded one-cycle strobes
// assumes the device samples strobes on rising mclk
`timescale 1ns/1ps
`default_nettype none
module rcr_host_model (
  input wire logic mclk,
  output logic [rcr_pkg::ADDR_W-1:0] reg_addr,
  output logic [rcr_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [rcr_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = '1;
    reg_wdata = '1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released lines show the inverse so a stale value never passes
  task automatic wr(input logic [rcr_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [rcr_pkg::ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- rcr_radio_regs_tb.sv ----
// self-checking bench for the radio control and revision registers
// assumes the host model owns the register strobes
`timescale 1ns/1ps
`default_nettype none
module rcr_radio_regs_tb;
  localparam logic [3:0] SREV = 4'h3; // arbitrary value
  localparam logic [3:0] PCODE = 4'h5; // arbitrary value
  localparam logic [5:0] CA = rcr_pkg::ADDR_RADIO_CTRL;
  localparam logic [5:0] IA = rcr_pkg::ADDR_REV_ID;
  logic mclk, rst, reg_wr, reg_rd, code_width_32, syn_lock, baseband_amp_req, settle_start;
  logic rx_mode, tx_mode, chips_32_mode, code_upper_half, amp_on, settle_busy, settle_done;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, lock_count, got, v;
  logic [31:0] s;
  int bad_count, tests_run, n;
  rcr_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rcr_radio_regs #(.SILICON_REV(SREV), .PRODUCT_CODE(PCODE)) dut_u (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .code_width_32(code_width_32), .lock_count(lock_count),
    .syn_lock(syn_lock), .baseband_amp_req(baseband_amp_req), .settle_start(settle_start),
    .rx_mode(rx_mode), .tx_mode(tx_mode), .chips_32_mode(chips_32_mode),
    .code_upper_half(code_upper_half), .amp_on(amp_on), .settle_busy(settle_busy),
    .settle_done(settle_done));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] t;
    t = x ^ (x << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic tally_and_finish();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bounded wait; a must-finish wait that runs out ends the run
  task automatic wdone(input int lim, input bit must);
    n = 0;
    while (settle_done !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (must && settle_done !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t settle timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic settle(input int lim, input bit must);
    @(posedge mclk);
    #1;
    settle_start = 1'b1;
    @(posedge mclk);
    #1;
    settle_start = 1'b0;
    chk1(settle_busy, 1'b1);
    wdone(lim, must);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    code_width_32 = 1'b0;
    lock_count = 8'h00;
    syn_lock = 1'b0;
    baseband_amp_req = 1'b0;
    settle_start = 1'b0;
    bad_count = 0;
    tests_run = 0;
    s = 32'h00000005;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    host_u.rd(CA, got);
    chk(got, rcr_pkg::RADIO_CTRL_RESET);
    chk({5'h00, rx_mode, tx_mode, amp_on}, 8'h00);
    host_u.rd(IA, got);
    chk(got, {SREV, PCODE});
    host_u.wr(IA, 8'hFF);
    host_u.rd(IA, got);
    chk(got, {SREV, PCODE});
    host_u.rd(6'h3F, got);
    chk(got, rcr_pkg::UNMAPPED_READ);
    $display("test ident done");
    for (int i = 0; i < 24; i++) begin
      s = xs(s);
      code_width_32 = s[8];
      baseband_amp_req = s[9];
      v = (i < 2) ? {8{i[0]}} : (s[7:0] & rcr_pkg::RESERVED_MASK);
      host_u.wr(CA, v);
      host_u.rd(CA, got);
      chk(got, v & rcr_pkg::RESERVED_MASK);
      chk1(rx_mode, v[7]);
      chk1(tx_mode, v[6]);
      chk1(chips_32_mode, s[8]);
      chk1(code_upper_half, v[5] & s[8]);
      chk1(amp_on, v[3] ? v[2] : s[9]);
    end
    $display("test control done");
    for (int k = 0; k < 2; k++) begin
      lock_count = k ? 8'h03 : 8'h00;
      host_u.wr(CA, 8'h10); // bypass for fixed settle time
      settle(400, 1'b1);
      chk1(n == lock_count * 100 + 1, 1'b1);
    end
    lock_count = 8'h19; // margin after lock
    host_u.wr(CA, 8'h00); // amplifier left to the baseband
    settle(2600, 1'b0);
    chk1(settle_done, 1'b0);
    chk1(settle_busy, 1'b1);
    syn_lock = 1'b1;
    wdone(2600, 1'b1);
    chk1(n >= 2501 && n <= 2510, 1'b1);
    $display("test settle done");
    host_u.wr(CA, 8'hC4);
    @(posedge mclk);
    #1;
    chk({6'h00, rx_mode, tx_mode}, 8'h03);
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    host_u.rd(CA, got);
    chk(got, 8'h00);
    chk({6'h00, rx_mode, tx_mode}, 8'h00);
    $display("test rereset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
